/* rtl/seq_pkg.sv */
// constants, register map and types for the dual shift register sequencer
`default_nettype none
package seq_pkg;
   localparam int REG_W = 8;
   localparam int VOICES = 2;
   localparam int TAPS = 4;
   localparam int TAP_FIRST = 4;
   localparam int DW = 32;
   localparam int AW = 5;
   localparam int BE_W = 4;
   localparam int DIP_W = 6;
   localparam int OPT_PER_VOICE = 3;
   localparam int ENVPER_W = 16;
   localparam int SRC_W = 3;
   localparam int SRC_STRIDE = 4;
   localparam int SRC_TAP_BIT = 2;
   localparam int IDX_LO = 2;
   localparam int IDX_W = 3;
   localparam logic [IDX_W-1:0] IDX_CTRL = 3'h0;
   localparam logic [IDX_W-1:0] IDX_CLKDIV = 3'h1;
   localparam logic [IDX_W-1:0] IDX_ENVPER = 3'h2;
   localparam logic [IDX_W-1:0] IDX_PATCH = 3'h3;
   localparam logic [IDX_W-1:0] IDX_STATUS = 3'h4;
   localparam int CTRL_PLAY = 0;
   localparam int CTRL_LOOP = 1;
   localparam int ST_BITS = 0;
   localparam int ST_MOD = 16;
   localparam int ST_EXT = 20;
   localparam int ST_CLK = 21;
   localparam int ST_DIP = 22;
   localparam logic [DW-1:0] CLKDIV_RST = 32'h017D_7840;
   localparam logic [ENVPER_W-1:0] ENVPER_RST = 16'h4000;
   localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;
   typedef enum logic [3:0] {
      MOD_OFF = 4'h1,
      MOD_MUTUAL = 4'h2,
      MOD_1TO2 = 4'h4,
      MOD_2TO1 = 4'h8
   } mod_sel_t;
   function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old_v,
         input logic [DW-1:0] new_v, input logic [BE_W-1:0] be);
      logic [DW-1:0] r;
      r = old_v;
      for (int i = 0; i < BE_W; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

/* rtl/voice_shift_register.sv */
// one voice shift register with insert and remove controls
`default_nettype none
module voice_shift_register #(
   parameter int W = seq_pkg::REG_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic step,
   input wire logic ins,
   input wire logic rem,
   input wire logic serial_in,
   output logic [W-1:0] bits_r
);
   import seq_pkg::*;

   logic in_bit;

   always_comb begin
      in_bit = ins ? 1'b1 : (rem ? 1'b0 : serial_in);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bits_r <= '0;
      end else if (step) begin
         bits_r <= {bits_r[W-2:0], in_bit};
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_hold_idle: assert property (!step |=> $stable(bits_r))
      else $error("register moved without a step");
   chk_insert_one: assert property (step && ins |=> bits_r[0])
      else $error("insert did not load a one");
   chk_remove_zero: assert property (step && !ins && rem |=> !bits_r[0])
      else $error("remove did not load a zero");
   chk_shift_order: assert property (step |=> bits_r[W-1:1] == $past(bits_r[W-2:0]))
      else $error("bits did not advance by one stage");
   chk_serial_take: assert property (step && !ins && !rem |=> bits_r[0] == $past(serial_in))
      else $error("serial level not taken");
endmodule // voice_shift_register
`default_nettype wire

/* rtl/shift_sequencer.sv */
// two-voice shift register sequencer with step clock and mode controls
// Contract
// - two independent voice registers, shared step
// - external rising edge shifts both registers
// - external clock present disables internal generator
// - play/pause toggles, no shifts while paused
// - pause also blocks external clock edges
// - clock output follows internal or external
// - taps at stages five to eight
// - fed-back tap recirculates bits unchanged
// - insert and remove buttons per register
// - serial input level sampled each step
// - tap bits and ladder value output
// - modulation selector cycles four states
// - per-voice gated loop toggle button
// - loop mode retriggers while trigger high
// - zero-crossing mode waits for crossing
// - six switches, three options per voice
`default_nettype none
module shift_sequencer #(
   parameter logic [seq_pkg::DW-1:0] CLKDIV_DEFAULT = seq_pkg::CLKDIV_RST,
   parameter logic [seq_pkg::ENVPER_W-1:0] ENVPER_DEFAULT = seq_pkg::ENVPER_RST
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [seq_pkg::AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [seq_pkg::DW-1:0] avs_writedata,
   input wire logic [seq_pkg::BE_W-1:0] avs_byteenable,
   output logic [seq_pkg::DW-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ext_clk_in,
   input wire logic ext_clk_present,
   input wire logic play_btn,
   input wire logic mod_btn,
   input wire logic [seq_pkg::VOICES-1:0] loop_btn,
   input wire logic [seq_pkg::VOICES-1:0] ins_btn,
   input wire logic [seq_pkg::VOICES-1:0] rem_btn,
   input wire logic [seq_pkg::VOICES-1:0] data_in,
   input wire logic [seq_pkg::VOICES-1:0] trig_in,
   input wire logic [seq_pkg::VOICES-1:0] zero_cross,
   input wire logic [seq_pkg::DIP_W-1:0] dip_sw,
   output logic clk_out,
   output logic step_pulse,
   output logic [seq_pkg::VOICES-1:0][seq_pkg::TAPS-1:0] tap_out,
   output logic [seq_pkg::VOICES-1:0][seq_pkg::REG_W-1:0] ladder_out,
   output logic fm_1to2_en,
   output logic fm_2to1_en,
   output logic [seq_pkg::VOICES-1:0] loop_mode,
   output logic [seq_pkg::VOICES-1:0] env_start,
   output logic [seq_pkg::VOICES-1:0] controlled_slew_mode,
   output logic [seq_pkg::VOICES-1:0] zero_cross_mode,
   output logic [seq_pkg::VOICES-1:0] exp_response
);
   import seq_pkg::*;

   localparam int V = VOICES;

   // two-stage synchronisers for every pin: four single pins, six per-voice pins, switches
   localparam int PIN_W = 4 + 6 * V + DIP_W;
   logic [PIN_W-1:0] pin_w, pin_m, pin_s;
   logic s_ext, s_pres, s_play, s_mod, p_ext, p_play, p_mod;
   logic [V-1:0] s_loop, s_ins, s_rem, s_dat, s_trig, s_zc, p_loop, p_trig, p_zc;
   logic [DIP_W-1:0] s_dip;

   assign pin_w = {ext_clk_in, ext_clk_present, play_btn, mod_btn, loop_btn, ins_btn, rem_btn, data_in, trig_in,
      zero_cross, dip_sw};
   assign {s_ext, s_pres, s_play, s_mod, s_loop, s_ins, s_rem, s_dat, s_trig, s_zc, s_dip} = pin_s;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_m <= '0;
         pin_s <= '0;
      end else begin
         pin_m <= pin_w;
         pin_s <= pin_m;
      end
   end

   // previous values for edge detection
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         p_ext <= 1'b0;
         p_play <= 1'b0;
         p_mod <= 1'b0;
         p_loop <= '0;
         p_trig <= '0;
         p_zc <= '0;
      end else begin
         p_ext <= s_ext;
         p_play <= s_play;
         p_mod <= s_mod;
         p_loop <= s_loop;
         p_trig <= s_trig;
         p_zc <= s_zc;
      end
   end

   logic ext_rise, play_press, mod_press;
   logic [V-1:0] loop_press, trig_rise, zc_rise;
   assign ext_rise = s_ext & ~p_ext;
   assign play_press = s_play & ~p_play;
   assign mod_press = s_mod & ~p_mod;
   assign loop_press = s_loop & ~p_loop;
   assign trig_rise = s_trig & ~p_trig;
   assign zc_rise = s_zc & ~p_zc;

   // register bus slave: one wait cycle per access
   logic ack_r, wr_en;
   logic [IDX_W-1:0] idx;
   logic [DW-1:0] rdata_r;
   logic play_r;
   logic [V-1:0] loop_r;
   logic [DW-1:0] clkdiv_r;
   logic [V-1:0][ENVPER_W-1:0] envper_r;
   logic [V-1:0][SRC_W-1:0] src_r;
   logic [DW-1:0] status_w;
   mod_sel_t mod_sel_r;
   logic int_clk_r;

   assign idx = avs_address[IDX_LO +: IDX_W];
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr_en = avs_write & ack_r;
   assign avs_readdata = rdata_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   always_comb begin
      status_w = ZERO_WORD;
      status_w[ST_BITS +: V*REG_W] = ladder_out;
      status_w[ST_MOD +: $bits(mod_sel_t)] = mod_sel_r;
      status_w[ST_EXT] = s_pres;
      status_w[ST_CLK] = clk_out;
      status_w[ST_DIP +: DIP_W] = s_dip;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= ZERO_WORD;
      end else if (avs_read && !ack_r) begin
         case (idx)
            IDX_CTRL: rdata_r <= DW'({loop_r, play_r});
            IDX_CLKDIV: rdata_r <= clkdiv_r;
            IDX_ENVPER: rdata_r <= envper_r;
            IDX_PATCH: rdata_r <= DW'({1'b0, src_r[1], 1'b0, src_r[0]});
            IDX_STATUS: rdata_r <= status_w;
            default: rdata_r <= ZERO_WORD;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clkdiv_r <= CLKDIV_DEFAULT;
         envper_r <= {V{ENVPER_DEFAULT}};
         src_r <= '0;
      end else if (wr_en) begin
         if (idx == IDX_CLKDIV) begin
            clkdiv_r <= be_merge(clkdiv_r, avs_writedata, avs_byteenable);
         end
         if (idx == IDX_ENVPER) begin
            envper_r <= be_merge(envper_r, avs_writedata, avs_byteenable);
         end
         if (idx == IDX_PATCH) begin
            for (int v = 0; v < V; v++) begin
               if (avs_byteenable[0]) begin
                  src_r[v] <= avs_writedata[v*SRC_STRIDE +: SRC_W];
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         play_r <= 1'b0;
      end else if (wr_en && idx == IDX_CTRL && avs_byteenable[0]) begin
         play_r <= avs_writedata[CTRL_PLAY];
      end else if (play_press) begin
         play_r <= ~play_r;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loop_r <= '0;
      end else if (wr_en && idx == IDX_CTRL && avs_byteenable[0]) begin
         loop_r <= avs_writedata[CTRL_LOOP +: V];
      end else begin
         loop_r <= loop_r ^ loop_press;
      end
   end
   assign loop_mode = loop_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mod_sel_r <= MOD_OFF;
      end else if (mod_press) begin
         case (mod_sel_r)
            MOD_OFF: mod_sel_r <= MOD_MUTUAL;
            MOD_MUTUAL: mod_sel_r <= MOD_1TO2;
            MOD_1TO2: mod_sel_r <= MOD_2TO1;
            MOD_2TO1: mod_sel_r <= MOD_OFF;
            default: mod_sel_r <= MOD_OFF;
         endcase
      end
   end
   assign fm_1to2_en = (mod_sel_r == MOD_MUTUAL) | (mod_sel_r == MOD_1TO2);
   assign fm_2to1_en = (mod_sel_r == MOD_MUTUAL) | (mod_sel_r == MOD_2TO1);

   // internal generator runs only without external clock
   logic [DW-1:0] div_cnt_r;
   logic int_rise;
   assign int_rise = play_r && !s_pres && !int_clk_r && (div_cnt_r + 1'b1 >= clkdiv_r);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_cnt_r <= ZERO_WORD;
         int_clk_r <= 1'b0;
      end else if (play_r && !s_pres) begin
         if (div_cnt_r + 1'b1 >= clkdiv_r) begin
            div_cnt_r <= ZERO_WORD;
            int_clk_r <= ~int_clk_r;
         end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
         end
      end
   end

   // external edge steps, pause blocks it
   assign step_pulse = play_r && (s_pres ? ext_rise : int_rise);
   assign clk_out = s_pres ? s_ext : int_clk_r;

   // switches one to three first voice
   always_comb begin
      for (int v = 0; v < V; v++) begin
         controlled_slew_mode[v] = s_dip[v*OPT_PER_VOICE];
         zero_cross_mode[v] = s_dip[v*OPT_PER_VOICE + 1];
         exp_response[v] = s_dip[v*OPT_PER_VOICE + 2];
      end
   end

   // one register per voice on shared step
   for (genvar v = 0; v < V; v++) begin : g_voice
      logic [REG_W-1:0] bits;
      logic ser;
      logic [ENVPER_W-1:0] cnt_r;
      logic loop_req, req, pend_r, fire;

      // tap fed back as serial input
      always_comb begin
         if (src_r[v][SRC_TAP_BIT]) begin
            ser = bits[TAP_FIRST + int'(src_r[v][1:0])];
         end else begin
            ser = s_dat[v];
         end
      end

      voice_shift_register #(.W(REG_W)) u_reg (
         .ref_clk(ref_clk),
         .rst(rst),
         .step(step_pulse),
         .ins(s_ins[v]),
         .rem(s_rem[v]),
         .serial_in(ser),
         .bits_r(bits)
      );

      // taps at stages five to eight
      assign tap_out[v] = bits[TAP_FIRST +: TAPS];
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            ladder_out[v] <= '0;
         end else begin
            ladder_out[v] <= bits;
         end
      end

      assign loop_req = loop_r[v] && s_trig[v] && (cnt_r + 1'b1 >= envper_r[v]);
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            cnt_r <= '0;
         end else if (!(loop_r[v] && s_trig[v]) || trig_rise[v] || loop_req) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
      assign req = trig_rise[v] | loop_req;

      assign fire = zero_cross_mode[v] ? ((pend_r | req) & zc_rise[v]) : req;
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            pend_r <= 1'b0;
         end else if (!zero_cross_mode[v] || fire) begin
            pend_r <= 1'b0;
         end else if (req) begin
            pend_r <= 1'b1;
         end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            env_start[v] <= 1'b0;
         end else begin
            env_start[v] <= fire;
         end
      end

      chk_zc_hold: assert property (@(posedge ref_clk) disable iff (rst)
            zero_cross_mode[v] && !zc_rise[v] |=> !env_start[v])
         else $error("envelope started without zero crossing");
      chk_loop_retrig: assert property (@(posedge ref_clk) disable iff (rst)
            loop_req && !zero_cross_mode[v] |-> ##1 env_start[v] ##1 !env_start[v])
         else $error("gated loop retrigger missing");
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_pause_block: assert property (!play_r |-> !step_pulse)
      else $error("step while paused");
   chk_int_stop: assert property (s_pres |=> $stable(int_clk_r))
      else $error("internal clock ran with external present");
   chk_ext_step: assert property (play_r && s_pres && s_ext && !p_ext |-> step_pulse)
      else $error("external edge did not step");
   chk_clk_follow: assert property (s_pres |-> clk_out == s_ext)
      else $error("clock output not following external");
   chk_mod_cycle: assert property (mod_press && mod_sel_r == MOD_2TO1 |=> mod_sel_r == MOD_OFF)
      else $error("selector did not wrap to off");
   chk_play_toggle: assert property (play_press && !wr_en |=> play_r != $past(play_r))
      else $error("play button did not toggle");
   chk_loop_toggle: assert property (loop_press[0] && !wr_en |=> loop_r[0] != $past(loop_r[0]))
      else $error("loop button did not toggle");
   chk_bus_wait: assert property ((avs_read || avs_write) && !ack_r |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
endmodule // shift_sequencer
`default_nettype wire

/* dv/ext_clock_src.sv */
// external step clock source and patched data lines for the sequencer bench
`default_nettype none
module ext_clock_src #(
   parameter int HP = 6
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic plug,
   input wire logic burst_go,
   input wire logic [7:0] burst_len,
   input wire logic [1:0] data_lvl,
   output logic ext_clk_in,
   output logic ext_clk_present,
   output logic burst_busy,
   output logic [1:0] data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] left_r;
   int cnt_r;
   assign burst_busy = (left_r != 9'h000);
   // clock stands low between bursts, each burst gives burst_len rising edges
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ext_clk_in <= 1'b0;
         left_r <= 9'h000;
         cnt_r <= 0;
      end else if (burst_go && !burst_busy) begin
         left_r <= {burst_len, 1'b0};
         cnt_r <= 0;
      end else if (burst_busy) begin
         cnt_r <= (cnt_r == HP - 1) ? 0 : cnt_r + 1;
         if (cnt_r == HP - 1) begin
            ext_clk_in <= ~ext_clk_in;
            left_r <= left_r - 9'h001;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      ext_clk_present <= plug;
      data_out <= data_lvl;
   end
endmodule // ext_clock_src
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the two-voice shift register sequencer
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import seq_pkg::*;
   logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, ext_clk_in, ext_clk_present, play_btn, mod_btn;
   logic clk_out, step_pulse, fm_1to2_en, fm_2to1_en, plug, burst_go, burst_busy, clk_q;
   logic [AW-1:0] avs_address;
   logic [DW-1:0] avs_writedata, avs_readdata, rd;
   logic [BE_W-1:0] avs_byteenable;
   logic [VOICES-1:0] loop_btn, ins_btn, rem_btn, data_in, trig_in, zero_cross, data_lvl;
   logic [VOICES-1:0] loop_mode, env_start, controlled_slew_mode, zero_cross_mode, exp_response;
   logic [DIP_W-1:0] dip_sw;
   logic [VOICES-1:0][TAPS-1:0] tap_out;
   logic [VOICES-1:0][REG_W-1:0] ladder_out;
   logic [7:0] burst_len, e0, e1;
   int failures, cmp_count, steps, clk_rise, envs, envs1;

   shift_sequencer #(.ENVPER_DEFAULT(16'h0008)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ext_clk_in(ext_clk_in), .ext_clk_present(ext_clk_present),
      .play_btn(play_btn), .mod_btn(mod_btn), .loop_btn(loop_btn), .ins_btn(ins_btn), .rem_btn(rem_btn),
      .data_in(data_in), .trig_in(trig_in), .zero_cross(zero_cross), .dip_sw(dip_sw), .clk_out(clk_out),
      .step_pulse(step_pulse), .tap_out(tap_out), .ladder_out(ladder_out), .fm_1to2_en(fm_1to2_en),
      .fm_2to1_en(fm_2to1_en), .loop_mode(loop_mode), .env_start(env_start),
      .controlled_slew_mode(controlled_slew_mode), .zero_cross_mode(zero_cross_mode),
      .exp_response(exp_response));
   ext_clock_src i_src (.ref_clk(ref_clk), .rst(rst), .plug(plug), .burst_go(burst_go), .burst_len(burst_len),
      .data_lvl(data_lvl), .ext_clk_in(ext_clk_in), .ext_clk_present(ext_clk_present),
      .burst_busy(burst_busy), .data_out(data_in));

   always #2.5 ref_clk = ~ref_clk;
   // event counters sampled where outputs are settled
   always @(negedge ref_clk) begin
      steps <= steps + (step_pulse === 1'b1);
      envs <= envs + (env_start[0] === 1'b1);
      envs1 <= envs1 + (env_start[1] === 1'b1);
      clk_rise <= clk_rise + (clk_out === 1'b1 && clk_q !== 1'b1);
      clk_q <= clk_out;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(negedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      @(posedge ref_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20)
         failures++;
      @(posedge ref_clk);
   endtask
   task automatic press(input int k);
      case (k)
         0: play_btn <= 1'b1;
         1: mod_btn <= 1'b1;
         default: loop_btn[k-2] <= 1'b1;
      endcase
      cyc(4);
      {play_btn, mod_btn, loop_btn} <= 4'h0;
      cyc(5);
   endtask
   task automatic wait_step();
      int n;
      for (n = 0; n < 100; n++) begin
         @(negedge ref_clk);
         if (step_pulse === 1'b1)
            break;
      end
      if (n == 100)
         failures++;
      @(posedge ref_clk);
   endtask
   task automatic do_step(input logic i0, input logic r0, input logic d1, input int tp);
      ins_btn[0] <= i0;
      rem_btn[0] <= r0;
      data_lvl[1] <= d1;
      wait_step();
      e0 = {e0[6:0], i0 ? 1'b1 : (r0 ? 1'b0 : e0[tp])};
      e1 = {e1[6:0], d1};
      cyc(2);
      @(negedge ref_clk);
      check("ladder0", ladder_out[0], e0);
      check("taps0", tap_out[0], e0[7:4]);
      check("ladder1", ladder_out[1], e1);
      check("taps1", tap_out[1], e1[7:4]);
      @(posedge ref_clk);
   endtask
   task automatic burst(input logic [7:0] n, input int exp_st);
      int s, c, k;
      s = steps;
      c = clk_rise;
      k = 0;
      burst_len <= n;
      burst_go <= 1'b1;
      @(posedge ref_clk);
      burst_go <= 1'b0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (burst_busy !== 1'b0 && k < 500);
      cyc(8);
      check("ext_steps", steps - s, exp_st);
      check("clk_copy", clk_rise - c, n);
   endtask

   task automatic t_shift();
      int s, c;
      logic [7:0] pat, dpat;
      pat = 8'hB2;
      dpat = 8'hC5;
      bus(1'b1, 5'h04, 32'h0000_0008);
      bus(1'b0, 5'h14, 32'h0000_0000);
      check("unmapped", rd, 32'h0000_0000);
      bus(1'b1, 5'h0C, 32'h0000_0007);
      bus(1'b1, 5'h00, 32'h0000_0001);
      s = steps;
      c = clk_rise;
      for (int i = 0; i < 17; i++)
         do_step(i < 8 && pat[7-i], i == 0 || (i < 8 && !pat[7-i]), dpat[i%8], 7);
      check("steps", steps - s, 17);
      check("int_clk", clk_rise - c, 17);
      // loop from the stage five tap instead
      bus(1'b1, 5'h0C, 32'h0000_0004);
      for (int i = 0; i < 5; i++)
         do_step(1'b0, 1'b0, dpat[i], 4);
      bus(1'b1, 5'h00, 32'h0000_0000);
      s = steps;
      cyc(60);
      check("paused", steps - s, 0);
      press(0);
      bus(1'b0, 5'h00, 32'h0000_0000);
      check("play_on", rd[0], 1'b1);
      press(0);
      bus(1'b0, 5'h00, 32'h0000_0000);
      check("play_off", rd[0], 1'b0);
   endtask
   task automatic t_ext();
      int s;
      plug <= 1'b1;
      bus(1'b1, 5'h00, 32'h0000_0001);
      cyc(6);
      s = steps;
      cyc(60);
      check("ext_only", steps - s, 0);
      bus(1'b0, 5'h10, 32'h0000_0000);
      check("ext_seen", rd[20], 1'b1);
      burst(8'h05, 5);
      bus(1'b1, 5'h00, 32'h0000_0000);
      burst(8'h04, 0);
      plug <= 1'b0;
   endtask
   task automatic t_modes();
      int e, f;
      logic [3:0] sel [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
      logic [1:0] fm [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
      for (int i = 0; i < 4; i++) begin
         press(1);
         bus(1'b0, 5'h10, 32'h0000_0000);
         check("sel", rd[19:16], sel[i]);
         check("fm", {fm_2to1_en, fm_1to2_en}, fm[i]);
      end
      press(2);
      check("loop0", loop_mode, 2'h1);
      press(3);
      check("loop1", loop_mode, 2'h3);
      bus(1'b1, 5'h08, 32'h0008_0008);
      trig_in <= 2'h3;
      cyc(8);
      e = envs;
      f = envs1;
      cyc(80);
      check("retrig", (envs - e) inside {[9:11]}, 1'b1);
      check("retrig1", (envs1 - f) inside {[9:11]}, 1'b1);
      trig_in <= 2'h0;
      cyc(8);
      e = envs;
      f = envs1;
      cyc(40);
      check("no_retrig", envs - e, 0);
      check("no_retrig1", envs1 - f, 0);
      press(2);
      press(3);
      check("loop_off", loop_mode, 2'h0);
      dip_sw <= 6'h22;
      cyc(6);
      check("zc_mode", zero_cross_mode, 2'h1);
      check("exp", exp_response, 2'h2);
      bus(1'b0, 5'h10, 32'h0000_0000);
      check("dips", rd[27:22], 6'h22);
      trig_in[0] <= 1'b1;
      e = envs;
      cyc(40);
      check("held", envs - e, 0);
      zero_cross[0] <= 1'b1;
      cyc(20);
      check("started", envs - e, 1);
      {trig_in, zero_cross} <= 4'h0;
      dip_sw <= 6'h09;
      cyc(6);
      check("slew", controlled_slew_mode, 2'h3);
      check("zc_off", zero_cross_mode, 2'h0);
   endtask

   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {avs_read, avs_write, play_btn, mod_btn, plug, burst_go} = 6'h00;
      {loop_btn, ins_btn, rem_btn, trig_in, zero_cross, data_lvl} = 12'h000;
      avs_address = 5'h00;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      dip_sw = 6'h00;
      burst_len = 8'h00;
      e0 = 8'h00;
      e1 = 8'h00;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      cyc(4);
      check("ladder_rst", ladder_out, 16'h0000);
      check("loop_rst", loop_mode, 2'h0);
      bus(1'b0, 5'h10, 32'h0000_0000);
      check("sel_rst", rd[19:16], 4'h1);
      t_shift();
      t_ext();
      t_modes();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      test_done();
   end
endmodule // tb
`default_nettype wire
